/* File: design/irc_ctrl.sv */
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
module irc_ctrl #(
  parameter int unsigned HALF_SLOT = irc_pkg::HALF_SLOT_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire irc_pkg::irc_radio_t radio_i,
  input wire logic tx_req_i,
  output logic inq_tx_o,
  output logic [4:0] inq_hop_o,
  output logic fhs_tx_o,
  output logic [1:0] scan_period_mode_field_o,
  output logic [15:0] hop_phase_o,
  output logic mand_scan_only_o,
  output logic poll_tx_o,
  output logic link_tx_o,
  output logic listen_o,
  output logic fallback_o,
  output logic link_up_o
);
  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  irc_pkg::irc_cfg_t cfg;
  logic [15:0] train_repeat_count;
  logic [15:0] inquiry_reply_timeout;
  logic [15:0] new_link_timeout;
  logic [15:0] keepalive;
  logic [7:0] wr_addr;
  logic wr_pend;
  logic [31:0] next_rdata;
  logic [31:0] status;
  logic [15:0] phase_off;
  logic [27:0] clkn;
  logic cmd_start;
  logic cmd_detach;
  logic soft_rst;
  logic addr_ok;

  assign addr_ok = hsel_i && hready_i && (htrans_i == irc_pkg::HTRANS_NONSEQ || htrans_i == irc_pkg::HTRANS_SEQ);
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite_i;
      wr_addr <= haddr_i[7:0];
    end
  end

  // read data registered in the address phase so it stands in the data phase
  always_comb begin
    case (haddr_i[7:0])
      irc_pkg::A_CTRL: next_rdata = {24'h000000, cfg};
      irc_pkg::A_STATUS: next_rdata = status;
      irc_pkg::A_TRAIN_REP: next_rdata = {16'h0000, train_repeat_count};
      irc_pkg::A_REPLY_TO: next_rdata = {16'h0000, inquiry_reply_timeout};
      irc_pkg::A_LINK_TO: next_rdata = {16'h0000, new_link_timeout};
      irc_pkg::A_KEEPALIVE: next_rdata = {16'h0000, keepalive};
      irc_pkg::A_PHASE: next_rdata = {phase_off, hop_phase_o};
      irc_pkg::A_CLKN: next_rdata = {4'h0, clkn};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h00000000;
    end else if (addr_ok && !hwrite_i) begin
      hrdata_o <= next_rdata;
    end
  end

  assign cmd_start = wr_pend && wr_addr == irc_pkg::A_CTRL && hwdata_i[irc_pkg::B_START];
  assign cmd_detach = wr_pend && wr_addr == irc_pkg::A_CTRL && hwdata_i[irc_pkg::B_DETACH];
  assign soft_rst = wr_pend && wr_addr == irc_pkg::A_CTRL && hwdata_i[irc_pkg::B_RESET];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg <= irc_pkg::CFG_RST;
      train_repeat_count <= 16'h0000;
      inquiry_reply_timeout <= irc_pkg::REPLY_TO_RST;
      new_link_timeout <= irc_pkg::LINK_TO_RST;
      keepalive <= irc_pkg::KEEPALIVE_RST;
    end else if (soft_rst) begin
      cfg <= irc_pkg::CFG_RST;
      train_repeat_count <= 16'h0000;
      inquiry_reply_timeout <= irc_pkg::REPLY_TO_RST;
      new_link_timeout <= irc_pkg::LINK_TO_RST;
      keepalive <= irc_pkg::KEEPALIVE_RST;
    end else if (wr_pend) begin
      case (wr_addr)
        irc_pkg::A_CTRL: cfg <= irc_pkg::irc_cfg_t'(hwdata_i[7:0]);
        irc_pkg::A_TRAIN_REP: train_repeat_count <= hwdata_i[15:0];
        irc_pkg::A_REPLY_TO: inquiry_reply_timeout <= hwdata_i[15:0];
        irc_pkg::A_LINK_TO: new_link_timeout <= hwdata_i[15:0];
        irc_pkg::A_KEEPALIVE: keepalive <= hwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // native clock and slot strobes
  // ----------------------------------------
  logic [31:0] div;
  logic half_tick;
  logic slot_start;
  logic m_slot;
  logic s_slot;
  logic slot_tick;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= 32'h00000000;
      half_tick <= 1'b0;
    end else begin
      half_tick <= (div == HALF_SLOT - 1);
      div <= (div == HALF_SLOT - 1) ? 32'h00000000 : div + 32'h00000001;
    end
  end

  // native clock keeps running through soft reset so the phase stays free
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      clkn <= 28'h0000000;
      slot_start <= 1'b0;
    end else begin
      slot_start <= half_tick;
      if (half_tick) begin
        clkn <= clkn + 28'h0000001;
      end
    end
  end

  assign m_slot = slot_start && clkn[1:0] == irc_pkg::SLOT_MASTER;
  assign s_slot = slot_start && clkn[1:0] == irc_pkg::SLOT_SLAVE;
  assign slot_tick = m_slot || s_slot;

  function automatic logic [15:0] dec_sat(input logic [15:0] v);
    dec_sat = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  endfunction : dec_sat

  // ----------------------------------------
  // inquirer
  // ----------------------------------------
  logic [3:0] hop_idx;
  logic [15:0] train_reps;
  logic train_b;
  logic [15:0] rep_need;
  logic [11:0] rep_min;

  always_comb begin
    case (cfg.sco_links)
      2'h0: rep_min = irc_pkg::REP_MIN_NONE;
      2'h1: rep_min = irc_pkg::REP_MIN_ONE;
      default: rep_min = irc_pkg::REP_MIN_TWO;
    endcase
    rep_need = (train_repeat_count > {4'h0, rep_min}) ? train_repeat_count : {4'h0, rep_min};
  end

  // two trains, switch after full repetitions
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hop_idx <= 4'h0;
      train_reps <= 16'h0000;
      train_b <= 1'b0;
    end else if (!cfg.inq_en || soft_rst) begin
      hop_idx <= 4'h0;
      train_reps <= 16'h0000;
      train_b <= 1'b0;
    end else if (slot_tick) begin
      hop_idx <= hop_idx + 4'h1;
      if (hop_idx == 4'(irc_pkg::TRAIN_SLOTS - 1)) begin
        if (train_reps == rep_need - 16'h0001) begin
          train_reps <= 16'h0000;
          train_b <= !train_b;
        end else begin
          train_reps <= train_reps + 16'h0001;
        end
      end
    end
  end

  // send in master slots, listen between, no acknowledgement of replies
  // inquiry hops on own clock, voice slots take priority
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      inq_tx_o <= 1'b0;
      inq_hop_o <= 5'h00;
    end else begin
      inq_tx_o <= cfg.inq_en && !soft_rst && m_slot && !radio_i.voice_slot;
      inq_hop_o <= {train_b, hop_idx};
    end
  end

  // ----------------------------------------
  // responder
  // ----------------------------------------
  irc_pkg::irc_resp_t rstate;
  logic [15:0] lfsr;
  logic [9:0] backoff_random_slots;
  logic [15:0] reply_left;
  logic frozen;
  logic [15:0] frozen_phase;
  logic [16:0] mand_left;
  logic [16:0] mand_load;
  logic reply_ok;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lfsr <= 16'hACE1;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  assign reply_ok = radio_i.inquiry_rx && !radio_i.voice_slot;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rstate <= irc_pkg::RS_IDLE;
      backoff_random_slots <= 10'h000;
      reply_left <= 16'h0000;
    end else if (soft_rst || !cfg.scan_en) begin
      rstate <= irc_pkg::RS_IDLE;
    end else begin
      case (rstate)
        irc_pkg::RS_IDLE: begin
          rstate <= irc_pkg::RS_SCAN;
        end
        irc_pkg::RS_SCAN: begin
          if (radio_i.inquiry_rx) begin
            backoff_random_slots <= lfsr[9:0];
            rstate <= irc_pkg::RS_BACKOFF;
          end
        end
        irc_pkg::RS_BACKOFF: begin
          if (slot_tick) begin
            if (backoff_random_slots == 10'h000) begin
              reply_left <= inquiry_reply_timeout;
              rstate <= irc_pkg::RS_RESP;
            end else begin
              backoff_random_slots <= backoff_random_slots - 10'h001;
            end
          end
        end
        irc_pkg::RS_RESP: begin
          // a voice slot suppresses the reply, keep waiting
          if (reply_ok) begin
            rstate <= irc_pkg::RS_SCAN;
          end else if (slot_tick) begin
            if (reply_left == 16'h0000) begin
              rstate <= irc_pkg::RS_IDLE;
            end else begin
              reply_left <= dec_sat(reply_left);
            end
          end
        end
        default: rstate <= irc_pkg::RS_IDLE;
      endcase
    end
  end

  // freeze hop phase, offset accumulates per reply
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      frozen <= 1'b0;
      frozen_phase <= 16'h0000;
      phase_off <= 16'h0000;
    end else if (soft_rst) begin
      frozen <= 1'b0;
      phase_off <= 16'h0000;
    end else begin
      if (rstate == irc_pkg::RS_SCAN && radio_i.inquiry_rx) begin
        frozen <= 1'b1;
        frozen_phase <= clkn[irc_pkg::PHASE_LSB +: 16];
      end
      if (rstate == irc_pkg::RS_RESP && reply_ok) begin
        phase_off <= phase_off + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fhs_tx_o <= 1'b0;
      hop_phase_o <= 16'h0000;
    end else begin
      fhs_tx_o <= rstate == irc_pkg::RS_RESP && reply_ok && !soft_rst && cfg.scan_en;
      hop_phase_o <= (frozen ? frozen_phase : clkn[irc_pkg::PHASE_LSB +: 16]) + phase_off;
    end
  end

  always_comb begin
    case (cfg.sp_mode)
      irc_pkg::SCAN_PERIOD_MODE_ZERO: mand_load = irc_pkg::MAND_SLOTS_ZERO;
      irc_pkg::SCAN_PERIOD_MODE_ONE: mand_load = irc_pkg::MAND_SLOTS_ONE;
      default: mand_load = irc_pkg::MAND_SLOTS_TWO;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mand_left <= 17'h00000;
    end else if (soft_rst) begin
      mand_left <= 17'h00000;
    end else if (fhs_tx_o && cfg.opt_scheme) begin
      mand_left <= mand_load;
    end else if (slot_tick && mand_left != 17'h00000) begin
      mand_left <= mand_left - 17'h00001;
    end
  end

  // mandatory only in backoff, for the sp_mode period after a reply, or without opt_scheme; mandatory alongside optional otherwise
  assign mand_scan_only_o = rstate == irc_pkg::RS_BACKOFF || mand_left != 17'h00000 || !cfg.opt_scheme;
  assign scan_period_mode_field_o = cfg.sp_mode;

  // ----------------------------------------
  // connection
  // ----------------------------------------
  irc_pkg::irc_conn_t cstate;
  logic [15:0] link_left;
  logic [15:0] keep_left;
  logic [2:0] skip;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cstate <= irc_pkg::CS_IDLE;
      link_left <= 16'h0000;
      fallback_o <= 1'b0;
    end else begin
      fallback_o <= 1'b0;
      if (soft_rst || cmd_detach) begin
        cstate <= irc_pkg::CS_IDLE;
      end else begin
        case (cstate)
          irc_pkg::CS_IDLE: begin
            if (cmd_start) begin
              link_left <= new_link_timeout;
              cstate <= cfg.master ? irc_pkg::CS_POLL : irc_pkg::CS_WAIT;
            end
          end
          irc_pkg::CS_POLL: begin
            if (m_slot) begin
              cstate <= irc_pkg::CS_WAIT;
            end
          end
          irc_pkg::CS_WAIT: begin
            if (cfg.master ? radio_i.pkt_rx : radio_i.poll_rx) begin
              cstate <= irc_pkg::CS_ACTIVE;
            end else if (slot_tick) begin
              if (link_left == 16'h0000) begin
                fallback_o <= 1'b1;
                cstate <= irc_pkg::CS_IDLE;
              end else begin
                link_left <= dec_sat(link_left);
              end
            end
          end
          irc_pkg::CS_ACTIVE: ;
          default: cstate <= irc_pkg::CS_IDLE;
        endcase
      end
    end
  end

  // keepalive and start slots follow master clock
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      keep_left <= 16'h0000;
      poll_tx_o <= 1'b0;
      link_tx_o <= 1'b0;
    end else begin
      poll_tx_o <= cstate == irc_pkg::CS_POLL && m_slot;
      link_tx_o <= 1'b0;
      if (cstate != irc_pkg::CS_ACTIVE) begin
        keep_left <= keepalive;
      end else if (cfg.master && m_slot) begin
        if (tx_req_i || keep_left == 16'h0000) begin
          link_tx_o <= 1'b1;
          keep_left <= keepalive;
        end else begin
          keep_left <= dec_sat(keep_left);
        end
      end else if (!cfg.master && s_slot && tx_req_i) begin
        link_tx_o <= 1'b1;
      end
    end
  end

  // listen in every cycle while linked as slave, skip slots of other packets
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      skip <= 3'h0;
    end else if (cstate != irc_pkg::CS_ACTIVE) begin
      skip <= 3'h0;
    end else if (radio_i.not_addressed) begin
      skip <= radio_i.pkt_slots;
    end else if (slot_tick && skip != 3'h0) begin
      skip <= skip - 3'h1;
    end
  end

  assign listen_o = !cfg.master && cstate == irc_pkg::CS_ACTIVE && skip == 3'h0;
  assign link_up_o = cstate == irc_pkg::CS_ACTIVE;

  assign status = {16'h0000, 5'h00, train_b, mand_left != 17'h00000, frozen,
                   1'b0, rstate, 2'h0, cstate};
endmodule : irc_ctrl

/* File: design/irc_pkg.sv */
package irc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned SLOT_NS = 625000;
  localparam int unsigned SLOT_CYC = SLOT_NS / CLK_NS;
  localparam int unsigned HALF_SLOT_CYC = SLOT_CYC / 2;
  localparam int unsigned TRAIN_US = 10000;
  localparam int unsigned TRAIN_SLOTS = (TRAIN_US * 1000) / SLOT_NS;
  localparam int unsigned SLOTS_PER_S = 1000000000 / SLOT_NS;
  localparam int unsigned MAND_S_ZERO = 20;
  localparam int unsigned MAND_S_ONE = 40;
  localparam int unsigned MAND_S_TWO = 60;
  localparam logic [16:0] MAND_SLOTS_ZERO = 17'(MAND_S_ZERO * SLOTS_PER_S);
  localparam logic [16:0] MAND_SLOTS_ONE = 17'(MAND_S_ONE * SLOTS_PER_S);
  localparam logic [16:0] MAND_SLOTS_TWO = 17'(MAND_S_TWO * SLOTS_PER_S);
  localparam logic [11:0] REP_MIN_NONE = 12'h100;
  localparam logic [11:0] REP_MIN_ONE = 12'h200;
  localparam logic [11:0] REP_MIN_TWO = 12'h300;
  localparam int unsigned PHASE_LSB = 12;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [1:0] SLOT_MASTER = 2'h0;
  localparam logic [1:0] SLOT_SLAVE = 2'h2;
  localparam logic [1:0] SCAN_PERIOD_MODE_ZERO = 2'h0;
  localparam logic [1:0] SCAN_PERIOD_MODE_ONE = 2'h1;
  localparam logic [1:0] SCAN_PERIOD_MODE_TWO = 2'h2;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_TRAIN_REP = 8'h08;
  localparam logic [7:0] A_REPLY_TO = 8'h0C;
  localparam logic [7:0] A_LINK_TO = 8'h10;
  localparam logic [7:0] A_KEEPALIVE = 8'h14;
  localparam logic [7:0] A_PHASE = 8'h18;
  localparam logic [7:0] A_CLKN = 8'h1C;
  localparam int unsigned B_START = 8;
  localparam int unsigned B_DETACH = 9;
  localparam int unsigned B_RESET = 10;
  localparam logic [15:0] REPLY_TO_RST = 16'h0100;
  localparam logic [15:0] LINK_TO_RST = 16'h0020;
  localparam logic [15:0] KEEPALIVE_RST = 16'h0010;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef struct packed {
    logic master;
    logic inq_en;
    logic scan_en;
    logic opt_scheme;
    logic [1:0] sco_links;
    logic [1:0] sp_mode;
  } irc_cfg_t;

  localparam irc_cfg_t CFG_RST = irc_cfg_t'(8'h00);

  typedef struct packed {
    logic inquiry_rx;
    logic fhs_rx;
    logic poll_rx;
    logic pkt_rx;
    logic not_addressed;
    logic [2:0] pkt_slots;
    logic voice_slot;
  } irc_radio_t;

  typedef enum logic [2:0] {RS_IDLE, RS_SCAN, RS_BACKOFF, RS_RESP} irc_resp_t;
  typedef enum logic [1:0] {CS_IDLE, CS_POLL, CS_WAIT, CS_ACTIVE} irc_conn_t;
endpackage : irc_pkg

/* File: bench/irc_monitor.sv */
`timescale 1ns/1ns
module irc_monitor #(
  parameter int unsigned HALF_SLOT = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire irc_pkg::irc_radio_t radio_i,
  input wire logic inq_tx_o,
  input wire logic fhs_tx_o,
  input wire logic mand_scan_only_o,
  input wire logic poll_tx_o,
  input wire logic link_tx_o,
  input wire logic fallback_o,
  input wire logic link_up_o
);
  // --------
  // helpers
  // --------
  int unsigned gap;
  logic polled;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gap <= 32'hFFFF;
    end else if (poll_tx_o || link_tx_o) begin
      gap <= 32'h0;
    end else if (gap < 32'hFFFF) begin
      gap <= gap + 32'h1;
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      polled <= 1'b0;
    end else if (poll_tx_o || radio_i.poll_rx) begin
      polled <= 1'b1;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // --------
  // checks
  // --------
  // reply needs inquiry
  AST_FHS_CAUSE: assert property (fhs_tx_o |-> $past(radio_i.inquiry_rx))
    else $error("reply without inquiry");
  AST_FHS_VOICE: assert property (fhs_tx_o |-> !$past(radio_i.voice_slot))
    else $error("reply over voice slot");
  AST_INQ_VOICE: assert property (inq_tx_o |-> !$past(radio_i.voice_slot))
    else $error("inquiry over voice slot");
  AST_FHS_GAP: assert property (fhs_tx_o |=> !fhs_tx_o [*2])
    else $error("reply repeated without backoff");
  AST_MAND_FHS: assert property (fhs_tx_o |=> mand_scan_only_o [*8])
    else $error("mandatory scan not held after reply");
  AST_LINK_POLL: assert property ($rose(link_up_o) |-> polled)
    else $error("link up without poll");
  AST_FALLBACK: assert property (fallback_o |-> !link_up_o)
    else $error("fallback while linked");
  AST_TX_GAP: assert property ((poll_tx_o || link_tx_o) |-> gap >= 3 * HALF_SLOT)
    else $error("transmit starts too close");
  COV_FHS: cover property (fhs_tx_o);
  COV_LINK: cover property ($rose(link_up_o));
  COV_FALLBACK: cover property (fallback_o);
endmodule : irc_monitor

bind irc_ctrl irc_monitor #(.HALF_SLOT(HALF_SLOT)) i_irc_monitor (.mclk_i(mclk_i), .rst_i(rst_i),
  .radio_i(radio_i), .inq_tx_o(inq_tx_o), .fhs_tx_o(fhs_tx_o), .mand_scan_only_o(mand_scan_only_o),
  .poll_tx_o(poll_tx_o), .link_tx_o(link_tx_o), .fallback_o(fallback_o), .link_up_o(link_up_o));

/* File: bench/irc_peer.sv */
`timescale 1ns/1ns
module irc_peer (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic poll_tx_i,
  input wire logic inq_i,
  input wire logic voice_i,
  input wire logic answer_en_i,
  input wire logic [3:0] delay_i,
  input wire logic poll_i,
  input wire logic skip_i,
  output irc_pkg::irc_radio_t radio_o
);
  logic [4:0] wait_cnt;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      radio_o <= irc_pkg::irc_radio_t'(9'h000);
      wait_cnt <= 5'h00;
    end else begin
      radio_o.inquiry_rx <= inq_i;
      radio_o.voice_slot <= voice_i;
      radio_o.pkt_rx <= (wait_cnt == 5'h01);
      // master side opens a slave link with its poll
      radio_o.poll_rx <= poll_i;
      // packet for another slave reserves three slots
      radio_o.not_addressed <= skip_i;
      radio_o.pkt_slots <= 3'h3;
      if (poll_tx_i && answer_en_i) begin
        wait_cnt <= {1'b0, delay_i} + 5'h01;
      end else if (wait_cnt != 5'h00) begin
        wait_cnt <= wait_cnt - 5'h01;
      end
    end
  end
endmodule : irc_peer

/* File: bench/irc_ctrl_bench.sv */
`timescale 1ns/1ns
module irc_ctrl_bench;
  localparam int unsigned HS = 8;
  localparam int unsigned SL = 16 * HS;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic tx_req = 1'b0;
  logic inq = 1'b0;
  logic voice = 1'b0;
  logic ans_en = 1'b1;
  logic peer_poll = 1'b0;
  logic skip_pkt = 1'b0;
  logic listen;
  logic [31:0] hrdata, rd;
  logic hready, hresp, inq_tx, fhs_tx, poll_tx, link_tx, fallback, link_up, mand;
  logic [4:0] inq_hop;
  logic [1:0] sp_field;
  irc_pkg::irc_radio_t radio;
  int err_count = 0;
  int samples_checked = 0;
  int fhs_n = 0;
  int poll_n = 0;
  int fb_n = 0;
  int inq_n = 0;
  time t0;

  always #4 mclk_i = ~mclk_i;

  irc_ctrl #(.HALF_SLOT(HS)) i_irc_ctrl (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .radio_i(radio), .tx_req_i(tx_req),
    .inq_tx_o(inq_tx), .inq_hop_o(inq_hop), .fhs_tx_o(fhs_tx), .scan_period_mode_field_o(sp_field),
    .hop_phase_o(), .mand_scan_only_o(mand), .poll_tx_o(poll_tx), .link_tx_o(link_tx), .listen_o(listen),
    .fallback_o(fallback), .link_up_o(link_up));
  irc_peer i_irc_peer (.mclk_i(mclk_i), .rst_i(rst_i), .poll_tx_i(poll_tx), .inq_i(inq), .voice_i(voice),
    .answer_en_i(ans_en), .delay_i(4'h9), .poll_i(peer_poll), .skip_i(skip_pkt), .radio_o(radio));

  always @(posedge mclk_i) begin
    if (fhs_tx === 1'b1) fhs_n <= fhs_n + 1;
    if (poll_tx === 1'b1) poll_n <= poll_n + 1;
    if (fallback === 1'b1) fb_n <= fb_n + 1;
    if (inq_tx === 1'b1) inq_n <= inq_n + 1;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel <= 1'b1;
    htrans <= irc_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge mclk_i);
    while (hready !== 1'b1) @(posedge mclk_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk_i);
    while (hready !== 1'b1) @(posedge mclk_i);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(posedge mclk_i);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask : rdc

  task automatic pulse_inq;
    @(posedge mclk_i);
    inq <= 1'b1;
    @(posedge mclk_i);
    inq <= 1'b0;
    repeat (6) @(posedge mclk_i);
  endtask : pulse_inq

  task automatic wait_rs(input logic [2:0] s);
    do bus(1'b0, irc_pkg::A_STATUS, 32'h0); while (rd[6:4] !== s);
  endtask : wait_rs

  task test_done;
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // watchdog: three backoffs of at most 1023 slots dominate the run
  initial begin
    repeat (90000) @(posedge mclk_i);
    err_count++;
    test_done;
  end

  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    // --------
    // registers
    // --------
    rdc(irc_pkg::A_CTRL, 32'h0);
    rdc(irc_pkg::A_REPLY_TO, 32'h100);
    rdc(irc_pkg::A_LINK_TO, 32'h20);
    rdc(irc_pkg::A_KEEPALIVE, 32'h10);
    rdc(8'h40, 32'h0);
    wr(irc_pkg::A_REPLY_TO, 32'h40);
    rdc(irc_pkg::A_REPLY_TO, 32'h40);
    for (int m = 0; m < 3; m++) begin
      wr(irc_pkg::A_CTRL, 32'h10 | 32'(m));
      cmp({30'h0, sp_field}, 32'(m));
      cmp({31'h0, mand}, 32'h0);
    end
    wr(irc_pkg::A_CTRL, 32'h0);
    cmp({31'h0, mand}, 32'h1);
    // --------
    // responder
    // --------
    wr(irc_pkg::A_CTRL, 32'h31);
    wait_rs(3'h1);
    pulse_inq;
    bus(1'b0, irc_pkg::A_STATUS, 32'h0);
    cmp({31'h0, rd[8]}, 32'h1);
    t0 = $time;
    wait_rs(3'h3);
    cmp({31'h0, ($time - t0) < 1030 * SL}, 32'h1);
    voice <= 1'b1;
    pulse_inq;
    cmp(32'(fhs_n), 32'h0);
    voice <= 1'b0;
    pulse_inq;
    cmp(32'(fhs_n), 32'h1);
    cmp({31'h0, mand}, 32'h1);
    // native clock is still below one 1.28 s step, so hop phase equals the offset
    rdc(irc_pkg::A_PHASE, 32'h00010001);
    wait_rs(3'h1);
    pulse_inq;
    wait_rs(3'h3);
    pulse_inq;
    cmp(32'(fhs_n), 32'h2);
    bus(1'b0, irc_pkg::A_PHASE, 32'h0);
    cmp({16'h0, rd[31:16]}, 32'h2);
    wait_rs(3'h1);
    pulse_inq;
    wait_rs(3'h3);
    t0 = $time;
    wait_rs(3'h1);
    cmp({31'h0, ($time - t0) >= 63 * SL && ($time - t0) < 70 * SL}, 32'h1);
    cmp(32'(fhs_n), 32'h2);
    // --------
    // inquirer and link
    // --------
    wr(irc_pkg::A_CTRL, 32'h40);
    while (inq_n < 2) @(posedge mclk_i);
    cmp({31'h0, inq_hop[4]}, 32'h0);
    wr(irc_pkg::A_CTRL, 32'h80);
    wr(irc_pkg::A_CTRL, 32'h180);
    while (link_up !== 1'b1) @(posedge mclk_i);
    cmp(32'(poll_n), 32'h1);
    tx_req <= 1'b1;
    @(posedge mclk_i);
    while (link_tx !== 1'b1) @(posedge mclk_i);
    bus(1'b0, irc_pkg::A_CLKN, 32'h0);
    cmp({30'h0, rd[1:0]}, {30'h0, irc_pkg::SLOT_MASTER});
    tx_req <= 1'b0;
    t0 = $time;
    while (link_tx !== 1'b1) @(posedge mclk_i);
    cmp({31'h0, ($time - t0) > 32 * SL && ($time - t0) < 36 * SL}, 32'h1);
    wr(irc_pkg::A_CTRL, 32'h280);
    cmp({31'h0, link_up}, 32'h0);
    rdc(irc_pkg::A_CTRL, 32'h80);
    ans_en <= 1'b0;
    wr(irc_pkg::A_CTRL, 32'h180);
    t0 = $time;
    while (fb_n == 0) @(posedge mclk_i);
    cmp({31'h0, ($time - t0) >= 31 * SL}, 32'h1);
    cmp({31'h0, link_up}, 32'h0);
    // slave side: link opens on the peer's poll
    wr(irc_pkg::A_CTRL, 32'h0);
    wr(irc_pkg::A_CTRL, 32'h100);
    peer_poll <= 1'b1;
    @(posedge mclk_i);
    peer_poll <= 1'b0;
    repeat (3) @(posedge mclk_i);
    cmp({31'h0, link_up}, 32'h1);
    cmp({31'h0, listen}, 32'h1);
    skip_pkt <= 1'b1;
    @(posedge mclk_i);
    skip_pkt <= 1'b0;
    repeat (2) @(posedge mclk_i);
    cmp({31'h0, listen}, 32'h0);
    repeat (64) @(posedge mclk_i);
    cmp({31'h0, listen}, 32'h1);
    wr(irc_pkg::A_CTRL, 32'h400);
    rdc(irc_pkg::A_CTRL, 32'h0);
    rdc(irc_pkg::A_REPLY_TO, 32'h100);
    cmp({31'h0, hresp}, 32'h0);
    test_done;
  end
endmodule : irc_ctrl_bench
